/* vpic_pkg.sv */
// vpic_pkg: constants and types of the vectored priority interrupt controller.
// assumes a single 10 MHz clock and an AXI4-Lite master with 12-bit byte addresses.
package vpic_pkg;

    localparam int NSRC     = 32;
    localparam int FAST_SRC = 0;
    localparam int SOFT_SRC = 1;
    localparam int EXT_LO   = 24;
    localparam int EXT_HI   = 29;

    // register byte offsets
    localparam logic [11:0] OFS_SMR  = 12'h000;
    localparam logic [11:0] OFS_SVR  = 12'h080;
    localparam logic [11:0] OFS_IVR  = 12'h100;
    localparam logic [11:0] OFS_FVR  = 12'h104;
    localparam logic [11:0] OFS_ISR  = 12'h108;
    localparam logic [11:0] OFS_IPR  = 12'h10C;
    localparam logic [11:0] OFS_IMR  = 12'h110;
    localparam logic [11:0] OFS_CISR = 12'h114;
    localparam logic [11:0] OFS_IECR = 12'h120;
    localparam logic [11:0] OFS_IDCR = 12'h124;
    localparam logic [11:0] OFS_ICCR = 12'h128;
    localparam logic [11:0] OFS_ISCR = 12'h12C;
    localparam logic [11:0] OFS_EOI  = 12'h130;
    localparam logic [11:0] OFS_SPU  = 12'h134;

    // source mode word fields
    localparam int SMR_PRIO_LO = 0;
    localparam int SMR_KIND_LO = 5;

    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;

    typedef struct packed {
        logic        awvalid;
        logic [11:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [11:0] araddr;
        logic        rready;
    } vpic_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } vpic_axi_rsp_t;

    // kind[0]: edge, kind[1]: high/rising for external sources
    typedef struct packed {
        logic [1:0] kind;
        logic [2:0] prio;
    } vpic_smr_t;

    typedef struct packed {
        logic [2:0] lvl;
        logic [4:0] src;
    } vpic_ctx_t;

    typedef struct packed {
        logic [NSRC-1:0][31:0] svr;
        vpic_smr_t [NSRC-1:0]  smr;
        logic [NSRC-1:0]       imr;
        logic [NSRC-1:0]       epend;
        logic [NSRC-1:0]       prev;
        logic [31:0]           spu;
        vpic_ctx_t [7:0]       stk;
        logic [3:0]            depth;
        vpic_ctx_t             ctx;
        logic                  spur;
        logic                  m_ok;
        vpic_ctx_t             m_ctx;
        logic                  normal_irq_request_line;
        logic                  fast_irq_request_line;
        logic                  aw_got;
        logic                  w_got;
        logic [11:0]           awaddr;
        logic [31:0]           wdata;
        logic [3:0]            wstrb;
        vpic_axi_rsp_t         rsp;
    } vpic_state_t;

endpackage

/* vpic_top.sv */
// vpic_top: vectored priority interrupt controller with AXI4-Lite registers.
// assumes all inputs synchronous to core_clk_in; request outputs are active high.
// Operation
// - vector read returns current source's vector
// - current is best unmasked pending at read
// - eight-level encoder drives normal request
// - equal priority: lowest source number wins
// - higher arrival before read gives newer vector
// - higher after read reasserts, pushes on read
// - end-of-service write pops nesting stack
// - normal-mode vector read drops request, clears edge
// - enable/disable commands, mask readable
// - set/clear commands act on edge sources
// - fast request only from fast input
// - fast input edge/level and polarity programmable
// - fast readout returns source vector zero
// - source one is software only
// - spurious vector when nothing valid pending
// - spurious holds both lines until end
// - protect mode pushes and acknowledges on write
// - protect mode context updates on write
// - normal mode ignores vector register writes
// - protect enable comes from outside block
// - step order per mode
// - internal kind only, external adds polarity
// - normal request from sources one upward
`timescale 1ns/1ns
module vpic_top
(
    input  wire logic                    core_clk_in,
    input  wire logic                    arst_n_in,
    input  wire vpic_pkg::vpic_axi_req_t axi_req_in,
    output vpic_pkg::vpic_axi_rsp_t      axi_rsp_out,
    input  wire logic                    fast_interrupt_input_in,
    input  wire logic [31:2]             irq_src_in,
    input  wire logic                    protect_mode_in,
    output logic                         normal_irq_request_line_out,
    output logic                         fast_irq_request_line_out
);

    vpic_pkg::vpic_state_t r_reg;
    vpic_pkg::vpic_state_t r_next;

    logic [31:0]        src_all;
    logic [31:0]        act;
    logic [31:0]        edge_msk;
    logic [31:0]        edge_evt;
    logic [31:0]        pend;
    logic [31:0]        mp;
    logic               found;
    logic [4:0]         best_src;
    logic [2:0]         best_lvl;
    logic               cand_ok;
    logic [31:0]        cand_vec;
    logic               aw_hs;
    logic               w_hs;
    logic               ar_hs;
    logic               wr_do;
    logic               rd_ivr;
    logic               wr_ivr;
    logic [31:0]        rd;
    logic [31:0]        d;
    vpic_pkg::vpic_ctx_t best_ctx;

    function automatic logic [31:0] f_merge(input logic [31:0] old_w,
                                            input logic [31:0] new_w,
                                            input logic [3:0]  strb);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return (old_w & ~m) | (new_w & m);
    endfunction

    function automatic logic f_is_ext(input int i);
        return (i == vpic_pkg::FAST_SRC) || (i >= vpic_pkg::EXT_LO && i <= vpic_pkg::EXT_HI);
    endfunction

    // push current context and take the new one, or enter spurious handling
    function automatic vpic_pkg::vpic_state_t f_ack(input vpic_pkg::vpic_state_t s,
                                                    input logic ok,
                                                    input vpic_pkg::vpic_ctx_t c);
        vpic_pkg::vpic_state_t t;
        t = s;
        if (ok)
        begin
            t.stk[s.depth[2:0]] = s.ctx;
            t.depth             = s.depth + 4'd1;
            t.ctx               = c;
            t.epend[c.src]      = 1'b0;
        end
        else
        begin
            t.spur = 1'b1;
        end
        return t;
    endfunction

    // source conditioning and priority encoder
    always_comb
    begin
        src_all  = {irq_src_in, 1'b0, fast_interrupt_input_in};
        act      = '0;
        edge_msk = '0;
        for (int i = 0; i < vpic_pkg::NSRC; i++)
        begin
            act[i]      = src_all[i] ^ (f_is_ext(i) && !r_reg.smr[i].kind[1]);
            edge_msk[i] = r_reg.smr[i].kind[0];
        end
        edge_evt = act & ~r_reg.prev & edge_msk;
        pend     = (edge_msk & r_reg.epend) | (~edge_msk & act);
        mp       = pend & r_reg.imr;
        found    = 1'b0;
        best_src = '0;
        best_lvl = '0;
        for (int i = vpic_pkg::NSRC - 1; i >= 1; i--)
        begin
            if (mp[i] && (!found || r_reg.smr[i].prio >= best_lvl))
            begin
                found    = 1'b1;
                best_src = 5'(i);
                best_lvl = r_reg.smr[i].prio;
            end
        end
        cand_ok  = found && (r_reg.depth == 4'd0 || best_lvl > r_reg.ctx.lvl);
        cand_vec = r_reg.svr[best_src];
        best_ctx = '{lvl: best_lvl, src: best_src};
    end

    assign aw_hs  = axi_req_in.awvalid && r_reg.rsp.awready;
    assign w_hs   = axi_req_in.wvalid && r_reg.rsp.wready;
    assign ar_hs  = axi_req_in.arvalid && r_reg.rsp.arready;
    assign wr_do  = r_reg.aw_got && r_reg.w_got;
    assign rd_ivr = ar_hs && axi_req_in.araddr == vpic_pkg::OFS_IVR;
    assign wr_ivr = wr_do && r_reg.awaddr == vpic_pkg::OFS_IVR;

    always_comb
    begin
        r_next      = r_reg;
        r_next.prev = act;
        rd          = vpic_pkg::WORD_ZERO;
        d           = f_merge(vpic_pkg::WORD_ZERO, r_reg.wdata, r_reg.wstrb);
        if (axi_req_in.bready && r_reg.rsp.bvalid)
            r_next.rsp.bvalid = 1'b0;
        if (axi_req_in.rready && r_reg.rsp.rvalid)
            r_next.rsp.rvalid = 1'b0;
        if (aw_hs)
        begin
            r_next.aw_got = 1'b1;
            r_next.awaddr = axi_req_in.awaddr;
        end
        if (w_hs)
        begin
            r_next.w_got = 1'b1;
            r_next.wdata = axi_req_in.wdata;
            r_next.wstrb = axi_req_in.wstrb;
        end
        if (wr_do)
        begin
            r_next.aw_got     = 1'b0;
            r_next.w_got      = 1'b0;
            r_next.rsp.bvalid = 1'b1;
            r_next.rsp.bresp  = vpic_pkg::RESP_OKAY;
            if (r_reg.awaddr < vpic_pkg::OFS_SVR)
            begin
                if (r_reg.wstrb[0])
                begin
                    r_next.smr[r_reg.awaddr[6:2]].kind = r_reg.wdata[vpic_pkg::SMR_KIND_LO+:2];
                    r_next.smr[r_reg.awaddr[6:2]].prio = r_reg.wdata[vpic_pkg::SMR_PRIO_LO+:3];
                end
            end
            else if (r_reg.awaddr < vpic_pkg::OFS_IVR)
            begin
                r_next.svr[r_reg.awaddr[6:2]] =
                    f_merge(r_reg.svr[r_reg.awaddr[6:2]], r_reg.wdata, r_reg.wstrb);
            end
            else
            begin
                case (r_reg.awaddr)
                    vpic_pkg::OFS_IVR:
                    begin
                        // external protect input: acknowledge on write
                        if (protect_mode_in)
                            r_next = f_ack(r_next, r_reg.m_ok, r_reg.m_ctx);
                    end
                    vpic_pkg::OFS_IECR: r_next.imr = r_next.imr | d;
                    vpic_pkg::OFS_IDCR: r_next.imr = r_next.imr & ~d;
                    // set and clear on edge sources
                    vpic_pkg::OFS_ICCR: r_next.epend = r_next.epend & ~(d & edge_msk);
                    vpic_pkg::OFS_ISCR: r_next.epend = r_next.epend | (d & edge_msk);
                    vpic_pkg::OFS_EOI:
                    begin
                        if (r_reg.spur)
                            r_next.spur = 1'b0;
                        else if (r_reg.depth != 4'd0)
                        begin
                            r_next.ctx   = r_reg.stk[3'(r_reg.depth - 4'd1)];
                            r_next.depth = r_reg.depth - 4'd1;
                        end
                    end
                    vpic_pkg::OFS_SPU: r_next.spu = f_merge(r_reg.spu, r_reg.wdata, r_reg.wstrb);
                    vpic_pkg::OFS_FVR, vpic_pkg::OFS_ISR, vpic_pkg::OFS_IPR, vpic_pkg::OFS_IMR,
                    vpic_pkg::OFS_CISR: r_next.rsp.bresp = vpic_pkg::RESP_OKAY;
                    default: r_next.rsp.bresp = vpic_pkg::RESP_SLVERR;
                endcase
            end
        end
        if (ar_hs)
        begin
            r_next.rsp.rvalid = 1'b1;
            r_next.rsp.rresp  = vpic_pkg::RESP_OKAY;
            if (axi_req_in.araddr < vpic_pkg::OFS_SVR)
            begin
                rd[vpic_pkg::SMR_KIND_LO+:2] = r_reg.smr[axi_req_in.araddr[6:2]].kind;
                rd[vpic_pkg::SMR_PRIO_LO+:3] = r_reg.smr[axi_req_in.araddr[6:2]].prio;
            end
            else if (axi_req_in.araddr < vpic_pkg::OFS_IVR)
            begin
                rd = r_reg.svr[axi_req_in.araddr[6:2]];
            end
            else
            begin
                case (axi_req_in.araddr)
                    vpic_pkg::OFS_IVR:
                    begin
                        // vector chosen at the read itself
                        rd            = cand_ok ? cand_vec : r_reg.spu;
                        // memorize always, acknowledge here in normal mode
                        r_next.m_ok   = cand_ok;
                        r_next.m_ctx  = best_ctx;
                        if (!protect_mode_in)
                        begin
                            r_next = f_ack(r_next, cand_ok, best_ctx);
                        end
                    end
                    vpic_pkg::OFS_FVR:
                    begin
                        rd = mp[vpic_pkg::FAST_SRC] ? r_reg.svr[vpic_pkg::FAST_SRC] : r_reg.spu;
                        if (!protect_mode_in)
                        begin
                            if (mp[vpic_pkg::FAST_SRC])
                            begin
                                r_next.epend[vpic_pkg::FAST_SRC] = 1'b0;
                            end
                            else
                            begin
                                r_next.spur = 1'b1;
                            end
                        end
                    end
                    vpic_pkg::OFS_ISR:  rd[4:0] = (r_reg.depth != 4'd0) ? r_reg.ctx.src : 5'h0;
                    vpic_pkg::OFS_IPR:  rd = pend;
                    vpic_pkg::OFS_IMR:  rd = r_reg.imr;
                    vpic_pkg::OFS_CISR: rd[1:0] = {r_reg.normal_irq_request_line, r_reg.fast_irq_request_line};
                    vpic_pkg::OFS_SPU:  rd = r_reg.spu;
                    vpic_pkg::OFS_IECR, vpic_pkg::OFS_IDCR, vpic_pkg::OFS_ICCR,
                    vpic_pkg::OFS_ISCR, vpic_pkg::OFS_EOI: rd = vpic_pkg::WORD_ZERO;
                    default: r_next.rsp.rresp = vpic_pkg::RESP_SLVERR;
                endcase
            end
            r_next.rsp.rdata = rd;
        end
        // new edges beat any clear in the same cycle
        r_next.epend = r_next.epend | edge_evt;
        // normal request from sources above current level
        r_next.normal_irq_request_line = !r_next.spur && found &&
                      (r_next.depth == 4'd0 || best_lvl > r_next.ctx.lvl);
        // fast request only from the fast input
        r_next.fast_irq_request_line = !r_next.spur && mp[vpic_pkg::FAST_SRC];
        r_next.rsp.awready = !r_next.aw_got && !r_next.rsp.bvalid;
        r_next.rsp.wready  = !r_next.w_got && !r_next.rsp.bvalid;
        r_next.rsp.arready = !r_next.rsp.rvalid;
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            r_reg <= '0;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign axi_rsp_out                 = r_reg.rsp;
    assign normal_irq_request_line_out = r_reg.normal_irq_request_line;
    assign fast_irq_request_line_out   = r_reg.fast_irq_request_line;

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!arst_n_in);

    a_vec_on_read: assert property (
        rd_ivr && cand_ok |=> axi_rsp_out.rdata == $past(cand_vec))
        else $error("vector readout does not match source vector");

    a_push_depth: assert property (
        rd_ivr && cand_ok && !protect_mode_in && !wr_do
        |=> r_reg.depth == $past(r_reg.depth) + 4'd1)
        else $error("stack not pushed on vector read");

    a_eoi_pop: assert property (
        wr_do && r_reg.awaddr == vpic_pkg::OFS_EOI && !r_reg.spur
        && r_reg.depth != 4'd0 && !ar_hs
        |=> r_reg.depth == $past(r_reg.depth) - 4'd1)
        else $error("stack not popped on end of service");

    a_ack_drop: assert property (
        rd_ivr && cand_ok && !protect_mode_in |=> !normal_irq_request_line_out)
        else $error("normal request still high after acknowledge");

    a_mask_read: assert property (
        ar_hs && axi_req_in.araddr == vpic_pkg::OFS_IMR
        |=> axi_rsp_out.rdata == $past(r_reg.imr))
        else $error("mask readback wrong");

    a_fiq_only: assert property (
        fast_irq_request_line_out |-> $past(mp[0]))
        else $error("fast request without fast source");

    a_spur_vec: assert property (
        rd_ivr && !cand_ok |=> axi_rsp_out.rdata == $past(r_reg.spu))
        else $error("spurious vector not returned");

    a_spur_quiet: assert property (
        r_reg.spur && !(wr_do && r_reg.awaddr == vpic_pkg::OFS_EOI)
        |=> r_reg.spur && !normal_irq_request_line_out && !fast_irq_request_line_out)
        else $error("request line high during spurious handling");

    a_prot_nopush: assert property (
        protect_mode_in && rd_ivr && !wr_do
        |=> r_reg.depth == $past(r_reg.depth) && r_reg.ctx == $past(r_reg.ctx))
        else $error("protect mode read changed context");

    a_norm_wr_ign: assert property (
        !protect_mode_in && wr_ivr && !ar_hs
        |=> r_reg.depth == $past(r_reg.depth) && r_reg.ctx == $past(r_reg.ctx))
        else $error("vector write acted in normal mode");

endmodule // vpic_top

/* vpic_core_model.sv */
// vpic_core_model: processor-side AXI4-Lite master used by the bench.
// assumes a shared rising-edge clock; every wait ends on a controller handshake.
`timescale 1ns/1ns
module vpic_core_model
(
    input  wire logic                    clk_in,
    input  wire vpic_pkg::vpic_axi_rsp_t axi_rsp_in,
    output vpic_pkg::vpic_axi_req_t      axi_req_out
);
    // response channels are always accepted, so bready/rready never toggle
    initial
    begin
        axi_req_out        = '0;
        axi_req_out.bready = 1'b1;
        axi_req_out.rready = 1'b1;
        axi_req_out.wstrb  = 4'hf;
    end

    // address and data offered together, each released when taken
    task automatic wr(input logic [11:0] addr, input logic [31:0] data,
                      output logic [1:0] resp);
        axi_req_out.awvalid <= 1'b1;
        axi_req_out.awaddr  <= addr;
        axi_req_out.wvalid  <= 1'b1;
        axi_req_out.wdata   <= data;
        do
        begin
            @(posedge clk_in);
            if (axi_rsp_in.awready)
                axi_req_out.awvalid <= 1'b0;
            if (axi_rsp_in.wready)
                axi_req_out.wvalid <= 1'b0;
        end
        while (!axi_rsp_in.bvalid);
        resp = axi_rsp_in.bresp;
    endtask

    task automatic rd(input logic [11:0] addr, output logic [31:0] data,
                      output logic [1:0] resp);
        axi_req_out.arvalid <= 1'b1;
        axi_req_out.araddr  <= addr;
        do
        begin
            @(posedge clk_in);
            if (axi_rsp_in.arready)
                axi_req_out.arvalid <= 1'b0;
        end
        while (!axi_rsp_in.rvalid);
        data = axi_rsp_in.rdata;
        resp = axi_rsp_in.rresp;
    endtask
endmodule // vpic_core_model

/* vectored_priority_interrupt_ctrl_bench.sv */
// vectored_priority_interrupt_ctrl_bench: register-level tests of the controller.
// assumes the core model as bus master; the bench drives sources and mode.
`timescale 1ns/1ns
module vectored_priority_interrupt_ctrl_bench;
    logic                    clk;
    logic                    arst_n;
    vpic_pkg::vpic_axi_req_t req;
    vpic_pkg::vpic_axi_rsp_t rsp;
    logic                    fast_src;
    logic [31:2]             irq_src;
    logic                    prot;
    logic                    normal_line;
    logic                    fast_line;
    int                      bad_count;
    int                      checks_done;
    logic [31:0]             rd_word;
    logic [1:0]              rd_resp;
    logic [1:0]              wr_resp;
    logic [1:0]              fkind [4];
    localparam logic [31:0]  SPU_VEC = 32'h0dea_d000;

    vpic_top i_dut
    (
        .core_clk_in                 (clk),
        .arst_n_in                   (arst_n),
        .axi_req_in                  (req),
        .axi_rsp_out                 (rsp),
        .fast_interrupt_input_in     (fast_src),
        .irq_src_in                  (irq_src),
        .protect_mode_in             (prot),
        .normal_irq_request_line_out (normal_line),
        .fast_irq_request_line_out   (fast_line)
    );

    vpic_core_model i_core
    (
        .clk_in      (clk),
        .axi_rsp_in  (rsp),
        .axi_req_out (req)
    );

    always #50 clk = ~clk;

    function automatic logic [31:0] vec(input int n);
        return 32'h0a00_0000 + 32'(n * 4);
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want)
        begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic wreg(input logic [11:0] addr, input logic [31:0] data);
        i_core.wr(addr, data, wr_resp);
    endtask

    task automatic rreg(input logic [11:0] addr, input logic [31:0] want);
        i_core.rd(addr, rd_word, rd_resp);
        chk(rd_word, want);
    endtask

    task automatic settle();
        repeat (4) @(posedge clk);
    endtask

    task automatic lines(input logic n_exp, input logic f_exp);
        settle();
        chk({30'b0, normal_line, fast_line}, {30'b0, n_exp, f_exp});
    endtask

    task automatic test_done();
        $display("checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        #(100 * 20000);
        bad_count++;
        test_done();
    end

    initial
    begin
        clk = 1'b0;
        arst_n = 1'b0;
        fast_src = 1'b1;
        irq_src = '0;
        irq_src[29:24] = 6'h3f;
        prot = 1'b0;
        bad_count = 0;
        checks_done = 0;
        fkind = '{2'h0, 2'h2, 2'h3, 2'h1};
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk);
        rreg(vpic_pkg::OFS_IMR, '0);
        for (int n = 0; n < 32; n++)
            wreg(vpic_pkg::OFS_SVR + 12'(n * 4), vec(n));
        wreg(vpic_pkg::OFS_SPU, SPU_VEC);
        rreg(vpic_pkg::OFS_SPU, SPU_VEC);
        rreg(vpic_pkg::OFS_IVR, SPU_VEC);
        wreg(vpic_pkg::OFS_SMR + 12'h004, 32'h0000_0022);
        rreg(vpic_pkg::OFS_SMR + 12'h004, 32'h0000_0022);
        wreg(vpic_pkg::OFS_IECR, 32'h0000_0002);
        wreg(vpic_pkg::OFS_ISCR, 32'h0000_0002);
        lines(1'b0, 1'b0);
        wreg(vpic_pkg::OFS_EOI, '0);
        lines(1'b1, 1'b0);
        rreg(vpic_pkg::OFS_IVR, vec(1));
        lines(1'b0, 1'b0);
        rreg(vpic_pkg::OFS_ISR, 32'h0000_0001);
        rreg(vpic_pkg::OFS_IPR, '0);
        // nested level source above the current one
        wreg(vpic_pkg::OFS_SMR + 12'h008, 32'h0000_0005);
        wreg(vpic_pkg::OFS_IECR, 32'h0000_0004);
        irq_src[2] <= 1'b1;
        lines(1'b1, 1'b0);
        rreg(vpic_pkg::OFS_IVR, vec(2));
        rreg(vpic_pkg::OFS_ISR, 32'h0000_0002);
        wreg(vpic_pkg::OFS_EOI, '0);
        rreg(vpic_pkg::OFS_ISR, 32'h0000_0001);
        lines(1'b1, 1'b0);
        wreg(vpic_pkg::OFS_EOI, '0);
        irq_src[2] <= 1'b0;
        lines(1'b0, 1'b0);
        // equal priorities, then a later higher one before the read
        wreg(vpic_pkg::OFS_SMR + 12'h00c, 32'h0000_0006);
        wreg(vpic_pkg::OFS_SMR + 12'h010, 32'h0000_0006);
        wreg(vpic_pkg::OFS_SMR + 12'h014, 32'h0000_0007);
        wreg(vpic_pkg::OFS_IECR, 32'h0000_0038);
        irq_src[4:3] <= 2'b11;
        lines(1'b1, 1'b0);
        irq_src[5] <= 1'b1;
        settle();
        rreg(vpic_pkg::OFS_IVR, vec(5));
        rreg(vpic_pkg::OFS_ISR, 32'h0000_0005);
        wreg(vpic_pkg::OFS_EOI, '0);
        irq_src[5] <= 1'b0;
        lines(1'b1, 1'b0);
        rreg(vpic_pkg::OFS_IVR, vec(3));
        lines(1'b0, 1'b0);
        wreg(vpic_pkg::OFS_EOI, '0);
        irq_src[4:3] <= 2'b00;
        wreg(vpic_pkg::OFS_IDCR, 32'h0000_0008);
        wreg(vpic_pkg::OFS_IMR, 32'hffff_ffff);
        chk({30'b0, wr_resp}, {30'b0, vpic_pkg::RESP_OKAY});
        rreg(vpic_pkg::OFS_IMR, 32'h0000_0036);
        irq_src[3] <= 1'b1;
        lines(1'b0, 1'b0);
        irq_src[3] <= 1'b0;
        wreg(vpic_pkg::OFS_ISCR, 32'h0000_0002);
        rreg(vpic_pkg::OFS_IPR, 32'h0000_0002);
        wreg(vpic_pkg::OFS_ICCR, 32'h0000_0002);
        rreg(vpic_pkg::OFS_IPR, '0);
        // external polarity: low level, then high level
        irq_src[24] <= 1'b0;
        settle();
        rreg(vpic_pkg::OFS_IPR, 32'h0100_0000);
        wreg(vpic_pkg::OFS_SMR + 12'h060, 32'h0000_0040);
        rreg(vpic_pkg::OFS_IPR, '0);
        irq_src[24] <= 1'b1;
        settle();
        rreg(vpic_pkg::OFS_IPR, 32'h0100_0000);
        // an external source drives the normal request
        wreg(vpic_pkg::OFS_IECR, 32'h0100_0000);
        lines(1'b1, 1'b0);
        wreg(vpic_pkg::OFS_IDCR, 32'h0100_0000);
        // fast source in each of its four kinds
        wreg(vpic_pkg::OFS_IECR, 32'h0000_0001);
        for (int k = 0; k < 4; k++)
        begin
            fast_src <= ~fkind[k][1];
            settle();
            wreg(vpic_pkg::OFS_SMR, {25'h000_0000, fkind[k], 5'h00});
            wreg(vpic_pkg::OFS_ICCR, 32'h0000_0001);
            lines(1'b0, 1'b0);
            fast_src <= fkind[k][1];
            lines(1'b0, 1'b1);
            rreg(vpic_pkg::OFS_CISR, 32'h0000_0001);
            rreg(vpic_pkg::OFS_FVR, vec(0));
            lines(1'b0, ~fkind[k][0]);
        end
        wreg(vpic_pkg::OFS_IDCR, 32'h0000_0001);
        wreg(vpic_pkg::OFS_ISCR, 32'h0000_0002);
        wreg(vpic_pkg::OFS_IVR, '0);
        lines(1'b1, 1'b0);
        rreg(vpic_pkg::OFS_CISR, 32'h0000_0002);
        prot <= 1'b1;
        settle();
        rreg(vpic_pkg::OFS_IVR, vec(1));
        lines(1'b1, 1'b0);
        i_core.rd(vpic_pkg::OFS_ISR, rd_word, rd_resp);
        chk({31'b0, rd_word[4:0] === 5'h01}, '0);
        wreg(vpic_pkg::OFS_IVR, '0);
        lines(1'b0, 1'b0);
        rreg(vpic_pkg::OFS_ISR, 32'h0000_0001);
        wreg(vpic_pkg::OFS_EOI, '0);
        prot <= 1'b0;
        i_core.rd(12'h118, rd_word, rd_resp);
        chk({30'b0, rd_resp}, {30'b0, vpic_pkg::RESP_SLVERR});
        i_core.wr(12'h118, 32'h0000_0001, wr_resp);
        chk({30'b0, wr_resp}, {30'b0, vpic_pkg::RESP_SLVERR});
        test_done();
    end
endmodule // vectored_priority_interrupt_ctrl_bench
